// >>> hdl/ubmu_pkg.sv
// Purpose: Shared constants and types for the break match unit
// Assumes: APB data 32 bits, register index times four is the byte address
// Notes:   Address and mask registers hold 16-bit halves; upper bits read as zero
package ubmu_pkg;
    // ------------------------------------------------------------
    // Register indices and APB address width
    // ------------------------------------------------------------
    localparam logic [9:0]  IDX_ADDR_HI   = 10'h090;
    localparam logic [9:0]  IDX_ADDR_LO   = 10'h092;
    localparam logic [9:0]  IDX_MASK_HI   = 10'h094;
    localparam logic [9:0]  IDX_MASK_LO   = 10'h096;
    localparam logic [9:0]  IDX_QUAL      = 10'h098;
    localparam logic [9:0]  IDX_STATUS    = 10'h09a;
    localparam int          ADDR_W        = 12;

    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [15:0] RST_HALF      = 16'h0000;
    localparam logic [7:0]  RST_QUAL      = 8'h00;
    localparam int          QUAL_SRC_POS  = 6;
    localparam int          QUAL_FD_POS   = 4;
    localparam int          QUAL_DIR_POS  = 2;
    localparam int          QUAL_SIZE_POS = 0;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic [1:0]  QUAL_NONE     = 2'h0;
    localparam logic [1:0]  SIZE_BYTE     = 2'h1;
    localparam logic [1:0]  SIZE_WORD     = 2'h2;
    localparam logic [1:0]  SIZE_LONG     = 2'h3;
    localparam logic [3:0]  BREAK_LEVEL   = 4'hf;
    localparam logic [3:0]  ACCEPT_MAX    = 4'he;
    localparam logic [31:0] SECOND_OFS    = 32'h0000_0002;

    // ------------------------------------------------------------
    // Monitored bus cycle
    // ------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic        is_dma;
        logic        is_fetch;
        logic        is_write;
        logic [1:0]  size;
        logic        dual;
    } ubmu_cycle_t;

    // Interrupt side handshake from the interrupt arbiter and CPU
    typedef struct packed {
        logic [3:0]  mask_level;
        logic        int_ok;
        logic        addr_err_busy;
        logic        earlier_int;
        logic [31:0] next_pc;
    } ubmu_cpu_t;
endpackage

// >>> hdl/ubmu_top.sv
// Purpose: Break comparator on CPU and DMA bus cycles with APB register access
// Assumes: Bus cycle and CPU status inputs come from logic on i_core_clk
// Notes:   APB answers with pready two cycles after setup
//
// Notes on behaviour
// [R01] Size qualifier 01 byte, 10 word, 11 long word.
// [R02] Fetches count as word size; software keeps low size bit zero.
// [R03] Data size is the transfer operand size, never the region width.
// [R04] Any source, fetch-data or direction pair at 00 blocks every break.
// [R05] Full match raises break request toward the interrupt arbiter.
// [R06] Request priority fifteen, accepted only when mask level fourteen or lower.
// [R07] At mask level fifteen request stays pending until actually taken.
// [R08] Dual fetch matches either instruction; second breaks after first executes.
// [R09] Fetch break taken before instruction; saved counter is break address.
// [R10] Delay slot or disabled point defers; saved counter is next acceptable. A deferred fetch break here saves the break address.
// [R11] Data break saves address following last executed instruction.
// [R12] Odd fetch match after branch waits for address error processing.
// [R13] DMA never fetches and fetches never write; such conditions never match.
// [R14] Condition change after first dual fetch leaves second break intact.
// [R15] Overrun fetches after taken branch or trap still match.
// [R16] Two cycles match to handling; earlier interrupts go first.
// [R17] Break address split into upper and lower halfword registers.
// [R18] Mask bit one excludes address bit, zero includes it.
// [R19] Qualifier pairs: 01 first kind, 10 second kind, 11 both.
// [R20] Size qualifier 00, the reset value, ignores access size.
// [R21] Match evaluated in issue cycle and registered before request.
`timescale 1ns/100ps
`default_nettype none
module ubmu_top (
    // Clock and reset
    input  wire logic                      i_core_clk,
    input  wire logic                      i_arst_n,
    // APB slave
    input  wire logic                      i_psel,
    input  wire logic                      i_penable,
    input  wire logic                      i_pwrite,
    input  wire logic [ubmu_pkg::ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]               i_pwdata,
    output logic                           o_pready,
    output logic [31:0]                    o_prdata,
    output logic                           o_pslverr,
    // Monitored bus cycle and CPU status
    input  wire ubmu_pkg::ubmu_cycle_t     i_cycle,
    input  wire ubmu_pkg::ubmu_cpu_t       i_cpu,
    input  wire logic                      i_break_ack,
    // Break request toward the interrupt arbiter
    output logic                           o_break_req,
    output logic [3:0]                     o_break_level,
    output logic                           o_break_take,
    output logic                           o_break_second,
    output logic [31:0]                    o_break_pc
);
    import ubmu_pkg::*;

    // ------------------------------------------------------------
    // Register file over APB
    // ------------------------------------------------------------
    logic [15:0] addr_hi_q, addr_hi_d, addr_lo_q, addr_lo_d;
    logic [15:0] mask_hi_q, mask_hi_d, mask_lo_q, mask_lo_d;
    logic [7:0]  qual_q, qual_d;
    logic        pready_q, pready_d, pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    logic [9:0]  idx;
    logic        mapped, wr_en, access;
    logic [31:0] rd_val;

    logic        pend_q, pend_d, second_q, second_d, fetch_q, fetch_d;
    logic        take_q, take_d, req_q, req_d, taken_q, taken_d;
    logic [31:0] pc_q, pc_d, baddr_q, baddr_d;

    assign idx    = i_paddr[ADDR_W-1:2];
    assign access = i_psel & i_penable;
    assign wr_en  = access & pready_q & i_pwrite & mapped;

    always_comb begin
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        unique case (idx)
            IDX_ADDR_HI: rd_val = {16'h0000, addr_hi_q};
            IDX_ADDR_LO: rd_val = {16'h0000, addr_lo_q};
            IDX_MASK_HI: rd_val = {16'h0000, mask_hi_q};
            IDX_MASK_LO: rd_val = {16'h0000, mask_lo_q};
            IDX_QUAL:    rd_val = {24'h000000, qual_q};
            IDX_STATUS:  rd_val = {29'h0, fetch_q, second_q, pend_q};
            default:     mapped = 1'b0;
        endcase
    end

    always_comb begin
        addr_hi_d = addr_hi_q;
        addr_lo_d = addr_lo_q;
        mask_hi_d = mask_hi_q;
        mask_lo_d = mask_lo_q;
        qual_d    = qual_q;
        pready_d  = access & ~pready_q;
        prdata_d  = prdata_q;
        pslverr_d = 1'b0;
        if (access & ~pready_q) begin
            prdata_d  = i_pwrite ? 32'h0000_0000 : rd_val;
            pslverr_d = ~mapped;
        end
        if (wr_en) begin
            unique case (idx)
                IDX_ADDR_HI: addr_hi_d = i_pwdata[15:0]; // R17
                IDX_ADDR_LO: addr_lo_d = i_pwdata[15:0]; // R17
                IDX_MASK_HI: mask_hi_d = i_pwdata[15:0];
                IDX_MASK_LO: mask_lo_d = i_pwdata[15:0];
                IDX_QUAL:    qual_d    = i_pwdata[7:0];
                default:     qual_d    = qual_q;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            addr_hi_q <= RST_HALF;
            addr_lo_q <= RST_HALF;
            mask_hi_q <= RST_HALF;
            mask_lo_q <= RST_HALF;
            qual_q    <= RST_QUAL; // R20
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            addr_hi_q <= addr_hi_d;
            addr_lo_q <= addr_lo_d;
            mask_hi_q <= mask_hi_d;
            mask_lo_q <= mask_lo_d;
            qual_q    <= qual_d;
            pready_q  <= pready_d;
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // ------------------------------------------------------------
    // Comparator
    // ------------------------------------------------------------
    logic [31:0] brk_addr, brk_mask, addr_a, addr_b;
    logic [1:0]  q_src, q_fd, q_dir, q_size, eff_size;
    logic        qual_ok, hit_a, hit_b, match_now;

    assign brk_addr = {addr_hi_q, addr_lo_q};
    assign brk_mask = {mask_hi_q, mask_lo_q};
    assign q_src    = qual_q[QUAL_SRC_POS+:2];
    assign q_fd     = qual_q[QUAL_FD_POS+:2];
    assign q_dir    = qual_q[QUAL_DIR_POS+:2];
    assign q_size   = qual_q[QUAL_SIZE_POS+:2];
    // Dual fetch brings two instructions; second one sits two bytes higher
    assign addr_a   = i_cycle.addr;
    assign addr_b   = i_cycle.addr + SECOND_OFS; // R08
    // Fetch always counts as word; data uses the operand size given
    assign eff_size = i_cycle.is_fetch ? SIZE_WORD : i_cycle.size; // R02 R03

    always_comb begin
        qual_ok = (q_src != QUAL_NONE) && (q_fd != QUAL_NONE)
                  && (q_dir != QUAL_NONE); // R04
        // First bit of each pair picks the first kind, second bit the other
        qual_ok = qual_ok && (i_cycle.is_dma ? q_src[1] : q_src[0]); // R19
        qual_ok = qual_ok && (i_cycle.is_fetch ? q_fd[0] : q_fd[1]); // R19
        qual_ok = qual_ok && (i_cycle.is_write ? q_dir[1] : q_dir[0]); // R19
        qual_ok = qual_ok && ((q_size == QUAL_NONE) || (q_size == eff_size)); // R01 R20
        // Illegal cycle kinds can never match
        qual_ok = qual_ok && !(i_cycle.is_fetch && (i_cycle.is_dma || i_cycle.is_write)); // R13
        hit_a   = ((addr_a ^ brk_addr) & ~brk_mask) == 32'h0000_0000; // R18
        hit_b   = i_cycle.is_fetch && i_cycle.dual
                  && (((addr_b ^ brk_addr) & ~brk_mask) == 32'h0000_0000); // R08
        match_now = i_cycle.valid && qual_ok && (hit_a || hit_b); // R05 R15
    end

    // ------------------------------------------------------------
    // Pending request and acceptance
    // ------------------------------------------------------------
    logic can_take;

    // Deferred for mask level, uninterruptible point, address error, prior interrupt
    assign can_take = pend_q && req_q && (i_cpu.mask_level <= ACCEPT_MAX) // R06
                      && i_cpu.int_ok // R10
                      && !i_cpu.addr_err_busy // R12
                      && !i_cpu.earlier_int // R16
                      && !take_q
                      && !taken_q; // R07

    always_comb begin
        pend_d   = pend_q;
        second_d = second_q;
        fetch_d  = fetch_q;
        baddr_d  = baddr_q;
        pc_d     = pc_q;
        req_d    = pend_q; // R16
        take_d   = can_take;
        // One acceptance per pending break; cleared when processing is done
        taken_d  = taken_q | can_take;
        if (can_take) begin
            // Fetch break saves the matched address; data break the next one
            pc_d = fetch_q ? baddr_q : i_cpu.next_pc; // R09 R11
        end
        if (i_break_ack) begin
            pend_d  = 1'b0; // R07
            taken_d = 1'b0;
        end
        // Captured in the issue cycle so later condition writes do not matter
        if (match_now && !pend_q) begin
            pend_d   = 1'b1; // R21 R14
            fetch_d  = i_cycle.is_fetch;
            second_d = i_cycle.is_fetch && !hit_a; // R08
            baddr_d  = hit_a ? addr_a : addr_b; // R09
        end else if (match_now) begin
            pend_d = 1'b1; // R07
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pend_q   <= 1'b0;
            second_q <= 1'b0;
            fetch_q  <= 1'b0;
            baddr_q  <= 32'h0000_0000;
            pc_q     <= 32'h0000_0000;
            req_q    <= 1'b0;
            take_q   <= 1'b0;
            taken_q  <= 1'b0;
        end else begin
            pend_q   <= pend_d;
            second_q <= second_d;
            fetch_q  <= fetch_d;
            baddr_q  <= baddr_d;
            pc_q     <= pc_d;
            req_q    <= req_d;
            take_q   <= take_d;
            taken_q  <= taken_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic [3:0] level_q;

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            level_q <= 4'h0;
        end else begin
            level_q <= BREAK_LEVEL; // R06
        end
    end

    assign o_pready       = pready_q;
    assign o_prdata       = prdata_q;
    assign o_pslverr      = pslverr_q;
    assign o_break_req    = req_q;
    assign o_break_level  = level_q;
    assign o_break_take   = take_q;
    assign o_break_second = second_q;
    assign o_break_pc     = pc_q;
endmodule
`default_nettype wire

// >>> hdl/ubmu_unused_guard.sv
`timescale 1ns/100ps

// >>> sim/ubmu_cpu_model.sv
// Purpose: CPU and arbiter stand-in that carries out break exception processing
// Assumes: Ack is a one-cycle pulse
// Notes:   i_delay sets how slowly processing follows acceptance
`timescale 1ns/100ps
`default_nettype none
module ubmu_cpu_model (
    // Clock, reset and control
    input  wire logic       i_core_clk,
    input  wire logic       i_arst_n,
    input  wire logic       i_break_take,
    input  wire logic [3:0] i_delay,
    // Processing done
    output logic            o_ack
);
    // ----
    // Ack only after acceptance
    // ----
    logic [3:0] cnt_q;
    logic       busy_q;
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            busy_q <= 1'b0;
            cnt_q  <= 4'h0;
            o_ack  <= 1'b0;
        end else begin
            o_ack <= 1'b0;
            if (i_break_take) begin
                busy_q <= 1'b1;
                cnt_q  <= i_delay;
            end else if (busy_q && cnt_q == 4'h0) begin
                busy_q <= 1'b0;
                o_ack  <= 1'b1;
            end else if (busy_q) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> sim/ubmu_top_sva.sv
// Purpose: Port checks for the break match unit
// Assumes: One clock domain
// Notes:   Bound onto ubmu_top
`timescale 1ns/100ps
`default_nettype none
module ubmu_top_sva (
    // Inputs watched
    input wire logic                  i_core_clk,
    input wire logic                  i_arst_n,
    input wire logic                  i_psel,
    input wire logic                  i_penable,
    input wire ubmu_pkg::ubmu_cycle_t i_cycle,
    input wire ubmu_pkg::ubmu_cpu_t   i_cpu,
    input wire logic                  i_break_ack,
    // Outputs watched
    input wire logic                  o_pready,
    input wire logic                  o_pslverr,
    input wire logic                  o_break_req,
    input wire logic [3:0]            o_break_level,
    input wire logic                  o_break_take
);
    import ubmu_pkg::*;
    // ----
    // Properties
    // ----
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    property p_level; o_break_req |-> o_break_level == 4'hf; endproperty
    a_level: assert property (p_level) else $error("request level wrong");
    property p_hold; o_break_req && !i_break_ack && !$past(i_break_ack) |=> o_break_req;
    endproperty
    a_hold: assert property (p_hold) else $error("pending request dropped");
    property p_cause; $rose(o_break_req) |-> $past(i_cycle.valid, 2); endproperty
    a_cause: assert property (p_cause) else $error("request without bus cycle");
    property p_gap; $rose(o_break_req) |-> !o_break_take; endproperty
    a_gap: assert property (p_gap) else $error("accepted too soon");
    property p_mask; o_break_take |-> $past(i_cpu.mask_level) <= 4'he; endproperty
    a_mask: assert property (p_mask) else $error("accepted at level 15");
    property p_point;
        o_break_take |-> $past(i_cpu.int_ok) && !$past(i_cpu.earlier_int)
            && !$past(i_cpu.addr_err_busy);
    endproperty
    a_point: assert property (p_point) else $error("accepted at bad point");
    property p_take; o_break_take |-> o_break_req ##1 !o_break_take; endproperty
    a_take: assert property (p_take) else $error("take not a pulse");
    property p_ready; i_psel && $rose(i_penable) |=> o_pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready on access");
    property p_err; o_pslverr |-> o_pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
endmodule
bind ubmu_top ubmu_top_sva u_sva (.i_core_clk, .i_arst_n, .i_psel, .i_penable, .i_cycle,
    .i_cpu, .i_break_ack, .o_pready, .o_pslverr, .o_break_req, .o_break_level, .o_break_take);
`default_nettype wire

// >>> sim/tb.sv
// Purpose: Self-checking bench for the break match unit
// Assumes: One wait state on APB
// Notes:   Bus cycles and CPU status come from the bench
`timescale 1ns/100ps
`default_nettype none
module tb;
    import ubmu_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, prdata, bpc;
    ubmu_cycle_t cy = '0;
    ubmu_cpu_t   cpu = '{4'h0, 1'b1, 1'b0, 1'b0, 32'h0000_0a00};
    logic [3:0]  dly = 4'h1, lvl;
    logic        slv, ack, pready, pslverr, req, take, second;
    int          err_total = 0, compares = 0, ncyc = 0;
    always #5 clk = ~clk;
    ubmu_top DUT (.i_core_clk(clk), .i_arst_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
        .o_prdata(prdata), .o_pslverr(pslverr), .i_cycle(cy), .i_cpu(cpu),
        .i_break_ack(ack), .o_break_req(req), .o_break_level(lvl), .o_break_take(take),
        .o_break_second(second), .o_break_pc(bpc));
    ubmu_cpu_model u_cpu (.i_core_clk(clk), .i_arst_n(rst_n), .i_break_take(take),
        .i_delay(dly), .o_ack(ack));
    // ----
    // Shared tasks
    // ----
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic conclude();
        $display("Compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [9:0] i, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'h0};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic setq(input logic [31:0] a, input logic [31:0] m, input logic [7:0] q);
        apb(1'b1, IDX_ADDR_HI, {16'h0, a[31:16]});
        apb(1'b1, IDX_ADDR_LO, {16'h0, a[15:0]});
        apb(1'b1, IDX_MASK_HI, {16'h0, m[31:16]});
        apb(1'b1, IDX_MASK_LO, {16'h0, m[15:0]});
        apb(1'b1, IDX_QUAL, {24'h0, q});
    endtask
    // Flags: dma, fetch, write, dual
    task automatic bus(input logic [31:0] a, input logic [3:0] f, input logic [1:0] sz);
        cy <= '{1'b1, a, f[3], f[2], f[1], sz, f[0]};
        @(posedge clk);
        cy.valid <= 1'b0;
    endtask
    task automatic brk(input logic [31:0] pc, input logic sec);
        int n;
        n = 0;
        while (take !== 1'b1 && n < 30) begin
            @(posedge clk);
            n++;
        end
        chk("take", 32'(take), 32'h1);
        chk("saved pc", bpc, pc);
        chk("second", 32'(second), 32'(sec));
        repeat (20) @(posedge clk);
        chk("req cleared", 32'(req), 32'h0);
    endtask
    task automatic nob();
        repeat (6) @(posedge clk);
        chk("no req", 32'(req), 32'h0);
    endtask
    task automatic hold();
        repeat (6) begin
            @(posedge clk);
            chk("held take", 32'(take), 32'h0);
        end
        chk("held req", 32'(req), 32'h1);
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_regs();
        chk("level", 32'(lvl), 32'hf);
        for (int k = 0; k < 5; k++) begin
            apb(1'b0, IDX_ADDR_HI + 10'(2 * k), 32'h0);
            chk("reset value", rd, 32'h0);
        end
        apb(1'b1, IDX_MASK_HI, 32'hffff_a5c3);
        apb(1'b0, IDX_MASK_HI, 32'h0);
        chk("mask hi", rd, 32'h0000_a5c3);
        apb(1'b0, 10'h0a0, 32'h0);
        chk("unmapped", 32'(slv), 32'h1);
        $display("t_regs done");
    endtask
    task automatic t_fetch();
        setq(32'h0000_0404, 32'h0, 8'h54);
        bus(32'h0000_0404, 4'b0100, 2'h2);
        brk(32'h0000_0404, 1'b0);
        setq(32'h0000_0402, 32'h0, 8'h54);
        bus(32'h0000_0400, 4'b0101, 2'h2);
        brk(32'h0000_0402, 1'b1);
        setq(32'h0000_0404, 32'h0, 8'h58);
        bus(32'h0000_0404, 4'b0110, 2'h2);
        nob();
        setq(32'h0000_0404, 32'h0, 8'h14);
        bus(32'h0000_0404, 4'b0100, 2'h2);
        nob();
        $display("t_fetch done");
    endtask
    task automatic t_data();
        for (int sz = 1; sz < 4; sz++) begin
            setq(32'h0012_3456, 32'h0, 8'h68 | 8'(sz));
            bus(32'h0012_3456, 4'b0010, (sz == 1) ? 2'h2 : 2'h1);
            nob();
            bus(32'h0012_3456, 4'b0010, 2'(sz));
            brk(cpu.next_pc, 1'b0);
        end
        setq(32'h0076_bcdc, 32'h0000_00ff, 8'ha7);
        bus(32'h0076_bc00, 4'b1000, 2'h3);
        brk(cpu.next_pc, 1'b0);
        bus(32'h0077_bcdc, 4'b1000, 2'h3);
        nob();
        $display("t_data done");
    endtask
    task automatic t_pend();
        cpu.mask_level <= 4'hf;
        dly <= 4'h6;
        setq(32'h0000_0404, 32'h0, 8'h54);
        bus(32'h0000_0404, 4'b0100, 2'h2);
        apb(1'b1, IDX_ADDR_LO, 32'h0000_0500);
        repeat (10) @(posedge clk);
        chk("held req", 32'(req), 32'h1);
        chk("held take", 32'(take), 32'h0);
        cpu <= '{4'he, 1'b0, 1'b0, 1'b0, 32'h0000_0a00};
        hold();
        cpu <= '{4'he, 1'b1, 1'b1, 1'b0, 32'h0000_0a00};
        hold();
        cpu <= '{4'he, 1'b1, 1'b0, 1'b1, 32'h0000_0a00};
        hold();
        cpu <= '{4'he, 1'b1, 1'b0, 1'b0, 32'h0000_0a00};
        brk(32'h0000_0404, 1'b0);
        $display("t_pend done");
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_regs();
        t_fetch();
        t_data();
        t_pend();
        conclude();
    end
    always @(posedge clk) begin
        ncyc++;
        if (ncyc == 20000) begin
            err_total++;
            conclude();
        end
    end
endmodule
`default_nettype wire
